/* gpio_cfg_pkg.sv */
// Constants for the indexed-configuration GPIO bank.
// Assumes an I/O-space host with one index port and one data port.
//
// Overview of operation
// - Configuration stays locked until the unlock key is written twice.
// - Writing the lock key to the index port relocks configuration.
// - Index 07h then data selects the logical device; GPIO is device 7.
// - GPIO pins drive only after bit 7 of register 30h, device 09h, is set; inputs read regardless.
// - Direction register E0h: one means input, zero means driven output.
// - Output pins: data register E1h bit is read/write and driven out.
// - Input pins: data bit reads the pin level and ignores writes.
// - Inversion register E2h bit one inverts pin/data value both ways.
// - Inversion bit zero passes pin and data value unchanged.
package gpio_cfg_pkg;

    // Port addresses in I/O space
    localparam logic [15:0] CFG_BASE      = 16'h002e;
    localparam logic [15:0] DATA_OFFSET   = 16'h0001;

    // Key bytes
    localparam logic [7:0]  UNLOCK_KEY    = 8'h87;
    localparam logic [7:0]  LOCK_KEY      = 8'haa;

    // Global and per-device register indices
    localparam logic [7:0]  IDX_LDN       = 8'h07;
    localparam logic [7:0]  IDX_FUNC_EN   = 8'h30;
    localparam logic [7:0]  IDX_PIN_DIR   = 8'he0;
    localparam logic [7:0]  IDX_PIN_VAL   = 8'he1;
    localparam logic [7:0]  IDX_PIN_POL   = 8'he2;

    // Logical device numbers
    localparam logic [7:0]  LDN_GPIO      = 8'h07;
    localparam logic [7:0]  LDN_ENABLE    = 8'h09;

    // Field position of the function enable
    localparam int unsigned FUNC_EN_BIT   = 7;

    // Pin count
    localparam int unsigned PIN_COUNT     = 8;

    // Reset values
    localparam logic [7:0]  RST_FUNC_EN   = 8'h00;
    localparam logic [7:0]  RST_PIN_DIR   = 8'hff;
    localparam logic [7:0]  RST_PIN_VAL   = 8'h00;
    localparam logic [7:0]  RST_PIN_POL   = 8'h00;
    localparam logic [7:0]  RST_INDEX     = 8'h00;
    localparam logic [7:0]  RST_LDN       = 8'h00;

    // Read answer for locked accesses; unmapped registers read 00h
    localparam logic [7:0]  READ_IDLE     = 8'hff;

    typedef enum logic [1:0]
    {
        KEY_LOCKED,
        KEY_SEEN,
        KEY_OPEN
    } key_state_t;

endpackage : gpio_cfg_pkg

/* indexed_config_gpio_bank.sv */
// Eight-pin GPIO bank behind an index/data configuration port pair.
// Assumes single-cycle io_wr/io_rd strobes on sys_clk and asynchronous pins.
`timescale 1ns/10ps
`default_nettype none

module indexed_config_gpio_bank
#(
    parameter int unsigned PINS = gpio_cfg_pkg::PIN_COUNT,
    parameter logic [15:0] BASE = gpio_cfg_pkg::CFG_BASE
)
(
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst,

    // Host I/O cycles
    input  wire logic [15:0]       io_addr,
    input  wire logic [7:0]        io_wdata,
    input  wire logic              io_wr,
    input  wire logic              io_rd,
    output var  logic [7:0]        io_rdata,
    output var  logic              io_rvalid,

    // GPIO pins
    input  wire logic [PINS-1:0]   gpio_in,
    output var  logic [PINS-1:0]   gpio_out,
    output var  logic [PINS-1:0]   gpio_oe
);
    import gpio_cfg_pkg::*;

    typedef struct packed
    {
        key_state_t        key;
        logic [7:0]        index;
        logic [7:0]        ldn;
        logic [7:0]        func_en;
        logic [PINS-1:0]   dir;
        logic [PINS-1:0]   val;
        logic [PINS-1:0]   pol;
        logic [PINS-1:0]   sync1;
        logic [PINS-1:0]   sync2;
        logic [PINS-1:0]   out;
        logic [PINS-1:0]   oe;
        logic [7:0]        rdata;
        logic              rvalid;
    } state_t;

    localparam state_t RESET_STATE = '{
        key:     KEY_LOCKED,
        index:   RST_INDEX,
        ldn:     RST_LDN,
        func_en: RST_FUNC_EN,
        dir:     RST_PIN_DIR[PINS-1:0],
        val:     RST_PIN_VAL[PINS-1:0],
        pol:     RST_PIN_POL[PINS-1:0],
        sync1:   '0,
        sync2:   '0,
        out:     '0,
        oe:      '0,
        rdata:   READ_IDLE,
        rvalid:  1'b0
    };

    localparam logic [15:0] DATA_ADDR = 16'(BASE + DATA_OFFSET);

    state_t q;
    state_t d;

    logic            idx_hit;
    logic            dat_hit;
    logic [PINS-1:0] pin_view;
    logic [PINS-1:0] val_view;

    // Input pins read back through the inversion, outputs read the latch
    for (genvar n = 0; n < PINS; n++)
    begin : pin_slice
        assign pin_view[n] = q.sync2[n] ^ q.pol[n];
        assign val_view[n] = q.dir[n] ? pin_view[n] : q.val[n];
    end

    // Function enable lives only in its own logical device
    function automatic logic func_reg_hit(input logic [7:0] ldn,
                                          input logic [7:0] index);
        return (ldn == LDN_ENABLE) && (index == IDX_FUNC_EN);
    endfunction : func_reg_hit

    // Zero-extend a pin-wide vector onto the byte-wide data port
    function automatic logic [7:0] widen(input logic [PINS-1:0] v);
        logic [7:0] r;
        r = '0;
        r[PINS-1:0] = v;
        return r;
    endfunction : widen

    // Register file read, decoded by logical device and index
    function automatic logic [7:0] read_reg(input state_t s,
                                            input logic [PINS-1:0] view);
        logic [7:0] r;
        r = 8'h00;
        if (s.index == IDX_LDN)
        begin
            r = s.ldn;
        end
        else if (func_reg_hit(s.ldn, s.index))
        begin
            r = s.func_en;
        end
        else if (s.ldn == LDN_GPIO)
        begin
            unique case (s.index)
                IDX_PIN_DIR: r = widen(s.dir);
                IDX_PIN_VAL: r = widen(view);
                IDX_PIN_POL: r = widen(s.pol);
                default:     r = 8'h00;
            endcase
        end
        return r;
    endfunction : read_reg

    always_comb
    begin
        idx_hit  = (io_addr == BASE);
        dat_hit  = (io_addr == DATA_ADDR);

        d        = q;
        d.sync1  = gpio_in;
        d.sync2  = q.sync1;
        d.rvalid = 1'b0;

        // Index port writes: key sequence or index selection
        if (io_wr && idx_hit)
        begin
            unique case (q.key)
                KEY_LOCKED:
                    d.key = (io_wdata == UNLOCK_KEY) ? KEY_SEEN
                                                     : KEY_LOCKED;
                KEY_SEEN:
                    d.key = (io_wdata == UNLOCK_KEY) ? KEY_OPEN
                                                     : KEY_LOCKED;
                KEY_OPEN:
                begin
                    if (io_wdata == LOCK_KEY)
                    begin
                        d.key = KEY_LOCKED;
                    end
                    else
                    begin
                        d.index = io_wdata;
                    end
                end
            endcase
        end
        else if ((io_wr || io_rd) && (idx_hit || dat_hit)
                 && q.key == KEY_SEEN)
        begin
            // Any other access to the index or data port between the two keys breaks the pair
            d.key = KEY_LOCKED;
        end

        // Data port writes, only while unlocked
        if (io_wr && dat_hit && q.key == KEY_OPEN)
        begin
            if (q.index == IDX_LDN)
            begin
                d.ldn = io_wdata;
            end
            else if (func_reg_hit(q.ldn, q.index))
            begin
                d.func_en = io_wdata;
            end
            else if (q.ldn == LDN_GPIO)
            begin
                unique case (q.index)
                    IDX_PIN_DIR: d.dir = io_wdata[PINS-1:0];
                    IDX_PIN_POL: d.pol = io_wdata[PINS-1:0];
                    // Input bits keep their latch; writes there are dropped
                    IDX_PIN_VAL: d.val = (q.val & q.dir)
                        | (io_wdata[PINS-1:0] & ~q.dir);
                    default: ;
                endcase
            end
        end

        // Reads answer one cycle later; locked reads see the idle value
        if (io_rd && (idx_hit || dat_hit))
        begin
            d.rvalid = 1'b1;
            if (q.key != KEY_OPEN)
            begin
                d.rdata = READ_IDLE;
            end
            else if (idx_hit)
            begin
                d.rdata = q.index;
            end
            else
            begin
                d.rdata = read_reg(q, val_view);
            end
        end

        // Pins drive only when the function is enabled and set to output
        d.oe  = d.func_en[FUNC_EN_BIT] ? ~d.dir : '0;
        d.out = d.val ^ d.pol;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            q <= RESET_STATE;
        end
        else
        begin
            q <= d;
        end
    end

    assign io_rdata  = q.rdata;
    assign io_rvalid = q.rvalid;
    assign gpio_out  = q.out;
    assign gpio_oe   = q.oe;

endmodule : indexed_config_gpio_bank

`default_nettype wire

/* gpio_pin_partner.sv */
// Pin-side model of the GPIO header.
// Assumes the board drives pad_level wherever the bank does not drive.
`timescale 1ns/10ps
`default_nettype none
module gpio_pin_partner
(
    // Board side
    input  wire logic [7:0] pad_level,
    // Bank side
    input  wire logic [7:0] drv,
    input  wire logic [7:0] oe,
    output var  logic [7:0] pin
);
    // Driven bits loop back, so readback never sees a stale pad
    assign pin = (oe & drv) | (~oe & pad_level);
endmodule : gpio_pin_partner
`default_nettype wire

/* gpio_bank_properties.sv */
// Port-level checks of the GPIO bank.
// Assumes it is bound to every bank instance.
`timescale 1ns/10ps
`default_nettype none
module gpio_bank_properties
#(
    parameter int unsigned PINS = 8,
    parameter logic [15:0] BASE = 16'h002e
)
(
    input wire logic            sys_clk,
    input wire logic            rst,
    input wire logic [15:0]     io_addr,
    input wire logic [7:0]      io_wdata,
    input wire logic            io_wr,
    input wire logic            io_rd,
    input wire logic [7:0]      io_rdata,
    input wire logic            io_rvalid,
    input wire logic [PINS-1:0] gpio_in,
    input wire logic [PINS-1:0] gpio_out,
    input wire logic [PINS-1:0] gpio_oe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic hit;
    assign hit = io_addr == BASE || io_addr == BASE + 16'h0001;
    read_answer_a: assert property (io_rd && hit |=> io_rvalid)
        else $error("read got no answer");
    no_stray_a: assert property (!(io_rd && hit) |=> !io_rvalid)
        else $error("answer without a read");
    wr_silent_a: assert property (io_wr |=> !io_rvalid)
        else $error("write gave an answer");
    rdata_hold_a: assert property (!io_rvalid && !$past(rst)
        |-> $stable(io_rdata)) else $error("read data moved");
    pins_quiet_a: assert property (!io_wr
        |=> $stable(gpio_oe) && $stable(gpio_out))
        else $error("pins moved without a write");
    foreign_wr_a: assert property (io_wr && !hit
        |=> $stable(gpio_oe) && $stable(gpio_out))
        else $error("foreign write moved pins");
    reset_pins_a: assert property (disable iff (1'b0) rst
        |=> gpio_oe == '0 && gpio_out == '0) else $error("pins after reset");
    reset_read_a: assert property (disable iff (1'b0) rst
        |=> io_rdata == 8'hff && !io_rvalid) else $error("read after reset");
endmodule : gpio_bank_properties
bind indexed_config_gpio_bank gpio_bank_properties #(.PINS(PINS),
    .BASE(BASE)) chk_u (.sys_clk(sys_clk), .rst(rst), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
    .io_rdata(io_rdata), .io_rvalid(io_rvalid), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe));
`default_nettype wire

/* test_indexed_config_gpio_bank.sv */
// Self-checking bench for the GPIO bank.
// Assumes the pin partner model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module test_indexed_config_gpio_bank;
    import gpio_cfg_pkg::*;
    logic        sys_clk = 0;
    logic        rst = 1;
    logic [15:0] io_addr = 0;
    logic [7:0]  io_wdata = 0;
    logic        io_wr = 0;
    logic        io_rd = 0;
    logic [7:0]  io_rdata, gpio_out, gpio_oe, gpio_in, got, r, p, v, lat;
    logic        io_rvalid;
    logic [7:0]  pads = 0;
    int          fails = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    localparam logic [15:0] DP = CFG_BASE + DATA_OFFSET;
    always #5 sys_clk = ~sys_clk;
    indexed_config_gpio_bank dut_u (.sys_clk(sys_clk), .rst(rst),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr),
        .io_rd(io_rd), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
        .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe));
    gpio_pin_partner pin_u (.pad_level(pads), .drv(gpio_out),
        .oe(gpio_oe), .pin(gpio_in));
    task automatic report_and_stop;
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop
    task automatic check(input string n, input logic [7:0] s, e);
        samples_checked++;
        if (s !== e)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        io_addr = a;
        io_wdata = d;
        io_wr = 1;
        @(negedge sys_clk);
        io_wr = 0;
    endtask : wr
    // Answer stands one cycle, so it is taken at the next falling edge
    task automatic rd_at(input logic [15:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        io_addr = a;
        io_rd = 1;
        @(negedge sys_clk);
        io_rd = 0;
        check("rvalid", {7'h00, io_rvalid}, 8'h01);
        d = io_rdata;
    endtask : rd_at
    task automatic rd(output logic [7:0] d);
        rd_at(DP, d);
    endtask : rd
    task automatic ireg(input logic [7:0] i, d);
        wr(CFG_BASE, i);
        wr(DP, d);
    endtask : ireg
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fails++;
            report_and_stop();
        end
    end
    initial
    begin
        void'($urandom(32'h2d72));
        repeat (16) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 0;
        check("oe rst", gpio_oe, 8'h00);
        check("out rst", gpio_out, 8'h00);
        wr(CFG_BASE, UNLOCK_KEY);
        rd(got); // Breaks the key pair
        check("locked", got, READ_IDLE);
        wr(CFG_BASE, UNLOCK_KEY);
        wr(CFG_BASE, UNLOCK_KEY);
        ireg(IDX_LDN, LDN_ENABLE);
        ireg(IDX_FUNC_EN, 8'h80);
        rd(got);
        check("func en", got, 8'h80);
        rd_at(CFG_BASE, got);
        check("index", got, IDX_FUNC_EN);
        $display("key test done");
        ireg(IDX_LDN, LDN_GPIO);
        wr(CFG_BASE, 8'he3);
        rd(got);
        check("unmapped", got, 8'h00);
        lat = RST_PIN_VAL;
        for (int i = 0; i < 5; i++)
        begin
            r = 8'($urandom);
            v = 8'($urandom);
            pads = 8'($urandom);
            p = (i == 0) ? 8'h00 : 8'($urandom);
            ireg(IDX_PIN_DIR, r);
            ireg(IDX_PIN_POL, p);
            ireg(IDX_PIN_VAL, v);
            lat = (lat & r) | (v & ~r);
            check("oe", gpio_oe, ~r);
            check("out", gpio_out & ~r, (lat ^ p) & ~r);
            rd(got);
            check("data", got, (lat & ~r) | ((pads ^ p) & r));
            $display("pin test %0d done", i);
        end
        // Dropped writes to input bits must leave the latch alone
        ireg(IDX_PIN_DIR, 8'h00);
        check("latch", gpio_out, lat ^ p);
        wr(CFG_BASE, LOCK_KEY);
        wr(DP, ~lat);
        rd(got);
        check("relocked", got, READ_IDLE);
        check("lock out", gpio_out, lat ^ p);
        $display("lock test done");
        report_and_stop();
    end
endmodule : test_indexed_config_gpio_bank
`default_nettype wire
